// File: hw/pct_pkg.sv
// constants shared by the prescaled countdown timer files
package pct_pkg;

    // clock rate and register width
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADR_W = 8;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_IEN = 8'h04;
    localparam logic [7:0] OFF_IST = 8'h08;
    localparam logic [7:0] OFF_ICLR = 8'h0C;
    localparam logic [7:0] OFF_PERIOD = 8'h10;
    localparam logic [7:0] OFF_COUNT = 8'h14;

    // control register field positions
    localparam int unsigned CTRL_DIS_BIT = 6;
    localparam int unsigned CTRL_REP_BIT = 5;
    localparam int unsigned CTRL_RUN_BIT = 4;
    localparam int unsigned CTRL_SEL_LSB = 0;
    localparam logic [15:0] CTRL_MASK = 16'h007F;

    // interrupt register layout
    localparam int unsigned IRQ_TIMER_BIT = 8;
    localparam logic [15:0] IRQ_TIMER_MASK = 16'h0100;
    localparam logic [15:0] IST_CLR_MASK = 16'h3130;
    localparam logic [15:0] IRQ_RSVD_MASK = 16'h48C0;

    // values after reset
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] IEN_RST = 16'h0000;
    localparam logic [15:0] IST_RST = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] DIV_RST = 16'h0000;

endpackage : pct_pkg

// File: hw/pct_tick_if.sv
// interface between timer core and prescaler
`timescale 1ns/1ps
`default_nettype none
interface pct_tick_if;
    logic run;
    logic ce;
    logic [3:0] sel;
    logic tick;
    modport ctl (output run, output ce, output sel, input tick);
    modport pre (input run, input ce, input sel, output tick);
endinterface : pct_tick_if
`default_nettype wire

// File: hw/pct_prescaler.sv
// power-of-two prescaler producing timer ticks
`timescale 1ns/1ps
`default_nettype none
module pct_prescaler #(
    parameter int unsigned DIV_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pct_tick_if.pre tb
);
    import pct_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic [DIV_W-1:0] mask;

    // low sel+1 bits all ones
    function automatic logic [DIV_W-1:0] div_mask(input logic [3:0] s);
        logic [DIV_W:0] m;
        m = ({{DIV_W{1'b0}}, 1'b1} << ({1'b0, s} + 5'h01));
        div_mask = m[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
    endfunction : div_mask

    // tick once per 2^(sel+1) cycles while running
    always_comb
    begin
        mask = div_mask(tb.sel);
        cnt_next = cnt_reg;
        if (tb.run)
        begin
            cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1}; // [RULE_04]
        end
    end

    assign tb.tick = tb.run && ((cnt_reg & mask) == mask); // [RULE_04]

    // divider counter, frozen while disabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= DIV_RST[DIV_W-1:0];
        end
        else if (tb.ce)
        begin
            cnt_reg <= cnt_next; // [RULE_01]
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_tick_spacing: assert property (tb.ce && tb.tick |=> !tb.tick) // [RULE_04]
        else $error("prescaler ticks on two cycles in a row");
    a_tick_full: assert property (tb.tick && tb.sel == 4'hF |-> &cnt_reg) // [RULE_04]
        else $error("slowest divide ticked before full count");
    a_tick_halt: assert property (!tb.run |-> !tb.tick) // [RULE_01]
        else $error("tick while prescaler disabled");

endmodule : pct_prescaler
`default_nettype wire

// File: hw/pct_timer.sv
// prescaled countdown timer with wishbone registers and interrupt
//
// Summary of operation
// RULE_01: disable bit stops timer and prescaler, keeps values
// RULE_02: repeat off stops at zero, on reloads period
// RULE_03: count-run off holds count, on counts down
// RULE_04: divider select gives clock over 2^(sel+1)
// RULE_05: enable mask bit gates each interrupt source
// RULE_06: pending bit reads one while interrupt recognized
// RULE_07: writing one to bits 4,5,8,12,13 clears
// RULE_08: count reaching zero raises timer interrupt
`timescale 1ns/1ps
`default_nettype none
module pct_timer #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned DIV_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pct_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [pct_pkg::REG_W-1:0] irq_src_i,
    output logic irq_o
);
    import pct_pkg::*;

    // register state
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] ien_reg;
    logic [15:0] ien_next;
    logic [15:0] ist_reg;
    logic [15:0] ist_next;
    logic [15:0] period_reg;
    logic [15:0] period_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic irq_reg;
    logic irq_next;

    // decoded bus and timer events
    logic req;
    logic wr;
    logic rd;
    logic tick;
    logic run_en;
    logic zero_evt;
    logic [15:0] clr_vec;
    logic [15:0] set_vec;
    logic [15:0] rdata;

    pct_tick_if tick_bus ();

    // byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0])
        begin
            r[7:0] = d[7:0];
        end
        if (s[1])
        begin
            r[15:8] = d[15:8];
        end
        merge16 = r;
    endfunction : merge16

    // address compare for a write
    function automatic logic wr_at(input logic w,
                                   input logic [7:0] a,
                                   input logic [7:0] off);
        wr_at = w && (a == off);
    endfunction : wr_at

    // prescaler link
    assign tick_bus.run = !ctrl_reg[CTRL_DIS_BIT]; // [RULE_01]
    assign tick_bus.ce = ce_i;
    assign tick_bus.sel = ctrl_reg[CTRL_SEL_LSB +: 4]; // [RULE_04]
    assign tick = tick_bus.tick;

    pct_prescaler #(
        .DIV_W(DIV_W)
    ) u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tb(tick_bus.pre)
    );

    // classic wishbone decode, one request per ack
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;

    // counter may step only when enabled and running
    assign run_en = !ctrl_reg[CTRL_DIS_BIT] && ctrl_reg[CTRL_RUN_BIT];
    assign zero_evt = tick && run_en &&
        (count_reg == {{(CNT_W-1){1'b0}}, 1'b1}); // [RULE_08]

    // next values of control, period and count
    always_comb
    begin
        ctrl_next = ctrl_reg;
        period_next = period_reg;
        count_next = count_reg;
        if (tick && run_en && (count_reg != '0)) // [RULE_03]
        begin
            if (zero_evt)
            begin
                if (ctrl_reg[CTRL_REP_BIT])
                begin
                    count_next = period_reg[CNT_W-1:0]; // [RULE_02]
                end
                else
                begin
                    count_next = '0; // [RULE_02]
                end
            end
            else
            begin
                count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE_03]
            end
        end
        if (wr_at(wr, wb_adr_i, OFF_CTRL))
        begin
            ctrl_next = merge16(ctrl_reg, wb_dat_i, wb_sel_i) & CTRL_MASK;
        end
        if (wr_at(wr, wb_adr_i, OFF_PERIOD))
        begin
            period_next = merge16(period_reg, wb_dat_i, wb_sel_i);
        end
        if (wr_at(wr, wb_adr_i, OFF_COUNT))
        begin
            count_next = merge16(count_reg, wb_dat_i, wb_sel_i);
        end
    end

    // next values of interrupt enable, pending flags and request
    always_comb
    begin
        ien_next = ien_reg;
        if (wr_at(wr, wb_adr_i, OFF_IEN))
        begin
            ien_next = merge16(ien_reg, wb_dat_i, wb_sel_i) & ~IRQ_RSVD_MASK;
        end
        clr_vec = 16'h0000;
        if (wr_at(wr, wb_adr_i, OFF_IST) || wr_at(wr, wb_adr_i, OFF_ICLR))
        begin
            clr_vec = merge16(16'h0000, wb_dat_i, wb_sel_i) & IST_CLR_MASK; // [RULE_07]
        end
        set_vec = irq_src_i & ~IRQ_TIMER_MASK;
        if (zero_evt)
        begin
            set_vec = set_vec | IRQ_TIMER_MASK; // [RULE_08]
        end
        // set wins over clear; other non-reserved bits follow their source level, reserved bits read zero
        ist_next = (((ist_reg & ~clr_vec) | set_vec) & IST_CLR_MASK) |
                   (irq_src_i & ~IST_CLR_MASK & ~IRQ_RSVD_MASK); // [RULE_06]
        irq_next = |(ist_next & ien_next); // [RULE_05]
    end

    // read mux and bus answer
    always_comb
    begin
        case (wb_adr_i)
            OFF_CTRL: rdata = ctrl_reg;
            OFF_IEN: rdata = ien_reg;
            OFF_IST: rdata = ist_reg;
            OFF_PERIOD: rdata = period_reg;
            OFF_COUNT: rdata = count_reg;
            default: rdata = 16'h0000;
        endcase
        dat_next = dat_reg;
        if (rd)
        begin
            dat_next = {16'h0000, rdata};
        end
        ack_next = req;
    end

    // timer registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= CTRL_RST;
            period_reg <= PERIOD_RST;
            count_reg <= COUNT_RST[CNT_W-1:0];
        end
        else if (ce_i)
        begin
            ctrl_reg <= ctrl_next;
            period_reg <= period_next;
            count_reg <= count_next;
        end
    end

    // interrupt registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ien_reg <= IEN_RST;
            ist_reg <= IST_RST;
            irq_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            ien_reg <= ien_next;
            ist_reg <= ist_next;
            irq_reg <= irq_next;
        end
    end

    // bus answer registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end
        else if (ce_i)
        begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_disable_freeze: assert property ( // [RULE_01]
        ce_i && ctrl_reg[CTRL_DIS_BIT] && !wr |=> $stable(count_reg))
        else $error("count moved while timer disabled");
    a_oneshot_stop: assert property ( // [RULE_02]
        ce_i && !ctrl_reg[CTRL_REP_BIT] && count_reg == '0 && !wr
        |=> count_reg == '0)
        else $error("one-shot timer left zero");
    a_auto_reload: assert property ( // [RULE_02]
        ce_i && zero_evt && ctrl_reg[CTRL_REP_BIT] && !wr
        |=> count_reg == $past(period_reg))
        else $error("repeat mode did not reload period");
    a_hold_count: assert property ( // [RULE_03]
        ce_i && !ctrl_reg[CTRL_RUN_BIT] && !wr |=> $stable(count_reg))
        else $error("count moved with count-run off");
    a_count_step: assert property ( // [RULE_03]
        ce_i && tick && run_en && count_reg > 1 && !wr
        |=> count_reg == $past(count_reg) - 1)
        else $error("count did not step down by one");
    a_irq_gate: assert property ( // [RULE_05]
        irq_o == |(ist_reg & ien_reg))
        else $error("interrupt output not gated by enable");
    a_pending_set: assert property ( // [RULE_08]
        ce_i && zero_evt |=> ist_reg[IRQ_TIMER_BIT] ##1 1'b1)
        else $error("zero reached without timer pending");
    a_reserved_zero: assert property ( // [RULE_06]
        (ist_reg & IRQ_RSVD_MASK) == 16'h0000)
        else $error("reserved pending bit set");
    a_w1c_clear: assert property ( // [RULE_07]
        ce_i && wr && wb_adr_i == OFF_IST && wb_sel_i[1] &&
        wb_dat_i[IRQ_TIMER_BIT] && !zero_evt
        |=> !ist_reg[IRQ_TIMER_BIT])
        else $error("write one did not clear timer pending");
    a_bus_ack: assert property (ce_i && req |=> wb_ack_o)
        else $error("bus request not acknowledged in one cycle");
    a_ack_pulse: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge stood for two cycles");
    a_ce_freeze: assert property (
        !ce_i |=> $stable(count_reg) && $stable(ist_reg) && $stable(irq_o))
        else $error("state moved with clock enable low");
    a_count_write: assert property (
        ce_i && wr && wb_adr_i == OFF_COUNT && wb_sel_i[1:0] == 2'b11
        |=> count_reg == $past(wb_dat_i[CNT_W-1:0]))
        else $error("count write lost against a timer step");
    a_oneshot_zero: assert property ( // [RULE_02]
        ce_i && zero_evt && !ctrl_reg[CTRL_REP_BIT] && !wr
        |=> count_reg == '0)
        else $error("one-shot timer did not stop at zero");
    a_mirror_bits: assert property ( // [RULE_06]
        ce_i |=> (ist_reg & ~(IST_CLR_MASK | IRQ_RSVD_MASK)) ==
        ($past(irq_src_i) & ~(IST_CLR_MASK | IRQ_RSVD_MASK)))
        else $error("live pending bit does not follow its source");

    c_reload: cover property (ce_i && zero_evt && ctrl_reg[CTRL_REP_BIT]);
    c_oneshot: cover property (ce_i && zero_evt && !ctrl_reg[CTRL_REP_BIT]);
    c_irq_rise: cover property ($rose(irq_o));
    c_clear_race: cover property (ce_i && zero_evt && clr_vec[IRQ_TIMER_BIT]);
    c_ce_stall: cover property (!ce_i && run_en && tick);

endmodule : pct_timer
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the prescaled countdown timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pct_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [15:0] src = 16'h0000;
    logic [31:0] dat_o;
    logic ack;
    logic irq;
    logic [15:0] q;
    logic [15:0] held;
    logic [31:0] seed = 32'h3F9395CC;
    logic [15:0] m_ctrl = 16'h0000;
    logic [15:0] m_ien = 16'h0000;
    logic [15:0] m_per = 16'h0000;
    logic [15:0] m_pend = 16'h0000;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    int dv;

    // device under test
    pct_timer pct_timer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack),
        .irq_src_i(src), .irq_o(irq)
    );

    // 20 MHz clock
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    // xorshift source of random values
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // value compare
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask : chk

    // interrupt level compare against the model
    task automatic chk_irq();
        cmp_count++;
        if (irq !== (|(m_pend & m_ien)))
        begin
            $display("MISMATCH irq exp %b got %b", |(m_pend & m_ien), irq);
            err_count++;
        end
    endtask : chk_irq

    // cycle count compare within a window
    task automatic chk_rng(input string nm, input int v, input int lo,
                           input int hi);
        cmp_count++;
        if (v < lo || v > hi)
        begin
            $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, v);
            err_count++;
        end
    endtask : chk_rng

    // one classic wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        dat <= {16'h0000, d};
        @(posedge clk_i);
        k = 1;
        while (ack !== 1'b1 && k < 50)
        begin
            @(posedge clk_i);
            k++;
        end
        q = dat_o[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1)
        begin
            $display("MISMATCH ack exp 1 got %b", ack);
            err_count++;
        end
        @(posedge clk_i);
    endtask : wb

    // write and update the model
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d);
        case (a)
            OFF_CTRL: m_ctrl = d & CTRL_MASK;
            OFF_IEN: m_ien = d & ~IRQ_RSVD_MASK;
            OFF_PERIOD: m_per = d;
            OFF_IST, OFF_ICLR: m_pend = m_pend & ~(d & IST_CLR_MASK);
            default: ;
        endcase
    endtask : wr

    // read and compare
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        chk(nm, e, q);
        chk("upper", 16'h0000, dat_o[31:16]);
    endtask : rd

    // wait for the interrupt line, counting cycles
    task automatic wirq(output int k);
        k = 0;
        while (irq !== 1'b1 && k < 2000)
        begin
            @(posedge clk_i);
            k++;
        end
    endtask : wirq

    // print counts and verdict, then stop
    task automatic results();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        results();
    end

    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++)
            rd("reset", 8'(i * 4), 16'h0000);
        repeat (4)
        begin
            wr(OFF_CTRL, 16'(rnd()));
            rd("ctrl", OFF_CTRL, m_ctrl);
            wr(OFF_IEN, 16'(rnd()));
            rd("ien", OFF_IEN, m_ien);
            wr(OFF_PERIOD, 16'(rnd()));
            rd("period", OFF_PERIOD, m_per);
        end
        wr(8'h20, 16'hFFFF);
        rd("unmapped", 8'h20, 16'h0000);
        wr(OFF_CTRL, 16'h0000);
        wr(OFF_IEN, 16'h0000);
        // sticky and mirrored sources, selective clearing
        src <= 16'h3030;
        @(posedge clk_i);
        src <= 16'h0201;
        m_pend = 16'h3030;
        @(posedge clk_i);
        rd("pend", OFF_IST, m_pend | 16'h0201);
        wr(OFF_IST, 16'hCEDF);
        rd("pend", OFF_IST, m_pend | 16'h0201);
        wr(OFF_ICLR, 16'h2000);
        rd("pend", OFF_IST, m_pend | 16'h0201);
        wr(OFF_IEN, 16'h1000);
        chk_irq();
        wr(OFF_IEN, 16'h0100);
        chk_irq();
        src <= 16'h0000;
        wr(OFF_IST, 16'hFFFF);
        rd("pend", OFF_IST, 16'h0000);
        // one-shot rate for each of the low divider codes
        for (int s = 0; s < 4; s++)
        begin
            dv = 2 << s;
            wr(OFF_CTRL, 16'h0010 | 16'(s));
            wr(OFF_COUNT, 16'h0003);
            wirq(n);
            chk_rng("rate", n, 2 * dv, 3 * dv + 3);
            rd("count", OFF_COUNT, 16'h0000);
            m_pend = IRQ_TIMER_MASK;
            rd("pend", OFF_IST, m_pend);
            chk_irq();
            wr(OFF_IST, IRQ_TIMER_MASK);
            chk_irq();
        end
        // auto reload: events keep coming at period ticks
        wr(OFF_PERIOD, 16'h0004);
        wr(OFF_CTRL, 16'h0030);
        wr(OFF_COUNT, 16'h0004);
        wirq(n);
        m_pend = IRQ_TIMER_MASK;
        wr(OFF_IST, IRQ_TIMER_MASK);
        wirq(n);
        chk_rng("reload", n + 3, 7, 9);
        // disable freezes count and period
        wr(OFF_CTRL, 16'h0070);
        m_pend = IRQ_TIMER_MASK;
        wr(OFF_IST, IRQ_TIMER_MASK);
        wb(1'b0, OFF_COUNT, 16'h0000);
        held = q;
        repeat (20) @(posedge clk_i);
        rd("count", OFF_COUNT, held);
        rd("period", OFF_PERIOD, 16'h0004);
        rd("pend", OFF_IST, 16'h0000);
        // count-run low holds the count
        wr(OFF_CTRL, 16'h0020);
        repeat (20) @(posedge clk_i);
        rd("count", OFF_COUNT, held);
        rd("pend", OFF_IST, 16'h0000);
        // clock enable low stalls the countdown
        wr(OFF_COUNT, 16'h0003);
        wr(OFF_CTRL, 16'h0010);
        ce_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        ce_i <= 1'b1;
        wirq(n);
        chk_rng("freeze", n, 4, 9);
        m_pend = IRQ_TIMER_MASK;
        rd("pend", OFF_IST, m_pend);
        chk_irq();
        // reset in mid-run clears every register
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        m_ctrl = 16'h0000;
        m_ien = 16'h0000;
        m_per = 16'h0000;
        m_pend = 16'h0000;
        for (int i = 0; i < 6; i++)
            rd("reset", 8'(i * 4), 16'h0000);
        chk_irq();
        results();
    end
endmodule : tb_top
`default_nettype wire
